// ---- rtl/pll_trim_regs.sv ----
// Behaviour
// - Reset strobe zeroes the loop's incremental phase offset, then self-clears.
// - Decrement strobe subtracts the programmed step size, then self-clears.
// - Increment strobe adds the programmed step size, then self-clears.
// - Loops one to three copy loop zero's controls at strides 0x20, 0x40, 0x60.
// - Trim top bits reset to zero; software writes them matching the low byte.
// - Status readback range is read-only; writes there change nothing.
// - A CRC mismatch during a memory transfer sets status bit three.
// - A transfer fault during a memory transfer sets status bit two; a CRC mismatch does not.
// - Status bit one stays high while a download is running.
// - Status bit zero stays high while an upload is running.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module pll_trim_regs
  import pll_trim_pkg::*;
(
  input  wire logic                              I_CLK_SYS,
  input  wire logic                              I_RST_B,
  input  wire logic                              I_PSEL,
  input  wire logic                              I_PENABLE,
  input  wire logic                              I_PWRITE,
  input  wire logic [ADDR_W-1:0]                 I_PADDR,
  input  wire logic [DATA_W-1:0]                 I_PWDATA,
  input  wire logic [3:0]                        I_PSTRB,
  input  wire logic                              I_EE_CRC_FAULT,
  input  wire logic                              I_EE_FAULT,
  input  wire logic                              I_EE_DOWNLOAD_BUSY,
  input  wire logic                              I_EE_UPLOAD_BUSY,
  output logic      [DATA_W-1:0]                 O_PRDATA,
  output logic                                   O_PREADY,
  output logic                                   O_PSLVERR,
  output logic      [NUM_LOOPS-1:0][PHASE_W-1:0] O_PHASE_OFFSET,
  output logic      [TRIM_W-1:0]                 O_REGULATOR_TRIM,
  output logic                                   O_IRQ
);

  typedef struct packed {
    bus_phase_t                    phase;
    logic [DATA_W-1:0]             prdata;
    logic                          pready;
    logic                          pslverr;
    logic [STEP_W-1:0]             step;
    logic [TRIM_W-1:0]             trim;
    ee_status_t                    live;
    ee_status_t                    shadow;
    logic [IRQ_W-1:0]              irq_status;
    logic [IRQ_W-1:0]              irq_enable;
    logic                          irq;
    phase_strobe_t [NUM_LOOPS-1:0] strobe;
  } regs_state_t;

  localparam regs_state_t STATE_RESET = '{
    phase:      BUS_IDLE,
    prdata:     '0,
    pready:     1'b0,
    pslverr:    1'b0,
    step:       STEP_RESET,
    trim:       TRIM_RESET,
    live:       '0,
    shadow:     '0,
    irq_status: IRQ_RESET,
    irq_enable: IRQ_RESET,
    irq:        1'b0,
    strobe:     '0
  };

  logic [1:0]        rst_sync;
  logic              rst_n;
  regs_state_t       st;
  regs_state_t       next_st;
  logic [IDX_W-1:0]  idx;
  logic              aligned;
  logic              wr_commit;
  logic [7:0]        wbyte;
  logic              xfer_start;
  logic [IRQ_W-1:0]  events;

  // Index of the phase strobe register of one loop
  function automatic logic [IDX_W-1:0] loop_phase_idx(input int k);
    loop_phase_idx = IDX_W'(int'(IDX_LOOP0_PHASE) + int'(IDX_LOOP_STRIDE) * k);
  endfunction

  // Whether an index names a register of this bank
  function automatic logic is_mapped(input logic [IDX_W-1:0] i);
    logic hit;
    hit = (i == IDX_XFER_STROBE) || (i == IDX_STEP_LOW) || (i == IDX_STEP_HIGH) ||
          (i == IDX_TRIM_LOW) || (i == IDX_TRIM_HIGH) ||
          (i >= IDX_EE_STATUS && i <= IDX_STATUS_LAST) ||
          (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_ENABLE) || (i == IDX_IRQ_CLEAR);
    for (int k = 0; k < NUM_LOOPS; k++) begin
      if (i == loop_phase_idx(k) || i == IDX_PHASE_READ0 + IDX_W'(k)) begin
        hit = 1'b1;
      end
    end
    is_mapped = hit;
  endfunction

  // Reset is applied at once but released through two stages
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n   = rst_sync[1];
  assign idx     = I_PADDR[IDX_W+1:2];
  assign aligned = (I_PADDR[1:0] == 2'b00) && (I_PADDR[ADDR_W-1:IDX_W+2] == '0);

  // A write lands only at the edge where the master sees pready high
  assign wr_commit = (st.phase == BUS_ACK) && I_PWRITE && !st.pslverr && I_PSTRB[0];
  assign wbyte     = I_PWDATA[7:0];

  // A new transfer wipes the previous fault flags
  assign xfer_start = (I_EE_DOWNLOAD_BUSY && !st.live.download) ||
                      (I_EE_UPLOAD_BUSY && !st.live.upload);

  // Interrupt events: faults, and the end of each transfer direction
  always_comb begin
    events                  = '0;
    events[IRQ_CRC_BIT]     = I_EE_CRC_FAULT;
    events[IRQ_FAULT_BIT]   = I_EE_FAULT;
    events[IRQ_DL_DONE_BIT] = st.live.download && !I_EE_DOWNLOAD_BUSY;
    events[IRQ_UL_DONE_BIT] = st.live.upload && !I_EE_UPLOAD_BUSY;
  end

  // Next-state logic for the bus, the bank and the status path
  always_comb begin
    next_st = st;

    // Strobes live for exactly one cycle, so software reads them as zero
    next_st.strobe = '0;

    // One wait state: ready and data come from flops on the second access cycle
    case (st.phase)
      BUS_IDLE: begin
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.prdata  = '0;
        if (I_PSEL && I_PENABLE) begin
          next_st.phase   = BUS_ACK;
          next_st.pready  = 1'b1;
          next_st.pslverr = !(aligned && is_mapped(idx));
          if (!I_PWRITE && aligned) begin
            case (idx)
              IDX_STEP_LOW:   next_st.prdata = DATA_W'(st.step[7:0]);
              IDX_STEP_HIGH:  next_st.prdata = DATA_W'(st.step[STEP_W-1:8]);
              IDX_TRIM_LOW:   next_st.prdata = DATA_W'(st.trim[7:0]);
              IDX_TRIM_HIGH:  next_st.prdata = DATA_W'(st.trim[TRIM_W-1:8]);
              IDX_EE_STATUS:  next_st.prdata = DATA_W'(st.shadow);
              IDX_IRQ_STATUS: next_st.prdata = DATA_W'(st.irq_status);
              IDX_IRQ_ENABLE: next_st.prdata = DATA_W'(st.irq_enable);
              default:        next_st.prdata = '0;
            endcase
            for (int k = 0; k < NUM_LOOPS; k++) begin
              if (idx == IDX_PHASE_READ0 + IDX_W'(k)) begin
                next_st.prdata = DATA_W'(O_PHASE_OFFSET[k]);
              end
            end
          end
        end
      end
      BUS_ACK: begin
        next_st.phase   = BUS_IDLE;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.prdata  = '0;
      end
      default: begin
        next_st.phase  = BUS_IDLE;
        next_st.pready = 1'b0;
      end
    endcase

    // Register writes; the status range has no write path at all
    if (wr_commit) begin
      case (idx)
        IDX_STEP_LOW:   next_st.step[7:0] = wbyte;
        IDX_STEP_HIGH:  next_st.step[STEP_W-1:8] = wbyte;
        IDX_TRIM_LOW:   next_st.trim[7:0] = wbyte;
        IDX_TRIM_HIGH:  next_st.trim[TRIM_W-1:8] = wbyte[1:0];
        IDX_IRQ_ENABLE: next_st.irq_enable = wbyte[IRQ_W-1:0];
        default:        next_st.step = next_st.step;
      endcase
      for (int k = 0; k < NUM_LOOPS; k++) begin
        if (idx == loop_phase_idx(k)) begin
          next_st.strobe[k].reset = wbyte[PH_RESET_BIT];
          next_st.strobe[k].dec   = wbyte[PH_DEC_BIT];
          next_st.strobe[k].inc   = wbyte[PH_INC_BIT];
        end
      end
    end

    // Live transfer status; a fault arriving with a new start still counts
    next_st.live.download = I_EE_DOWNLOAD_BUSY;
    next_st.live.upload   = I_EE_UPLOAD_BUSY;
    if (xfer_start) begin
      next_st.live.crc_fault = 1'b0;
      next_st.live.fault     = 1'b0;
    end
    if (I_EE_CRC_FAULT) begin
      next_st.live.crc_fault = 1'b1;
    end
    if (I_EE_FAULT) begin
      next_st.live.fault = 1'b1;
    end

    // The readable copy refreshes only on the transfer strobe
    if (wr_commit && idx == IDX_XFER_STROBE && wbyte == XFER_VALUE) begin
      next_st.shadow = st.live;
    end

    // Sticky interrupt bits; an event in the clearing cycle is kept
    if (wr_commit && idx == IDX_IRQ_CLEAR) begin
      next_st.irq_status = st.irq_status & ~wbyte[IRQ_W-1:0];
    end
    next_st.irq_status = next_st.irq_status | events;
    next_st.irq        = |(next_st.irq_status & next_st.irq_enable);
  end

  // Whole bank state registered in one place
  always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // One accumulator per loop; all share the step size
  genvar g;
  generate
    for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
      phase_offset_accum u_accum (
        .i_clk    (I_CLK_SYS),
        .i_rst_n  (rst_n),
        .i_strobe (st.strobe[g]),
        .i_step   (st.step),
        .o_offset (O_PHASE_OFFSET[g])
      );
    end
  endgenerate

  assign O_PRDATA         = st.prdata;
  assign O_PREADY         = st.pready;
  assign O_PSLVERR        = st.pslverr;
  assign O_REGULATOR_TRIM = st.trim;
  assign O_IRQ            = st.irq;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!rst_n);

  a_loop_stride: assert property (
    wr_commit && idx == loop_phase_idx(NUM_LOOPS - 1) && wbyte[PH_INC_BIT]
    |=> st.strobe[3].inc && !st.strobe[0].inc)
    else $error("loop three strobe not decoded at its stride");
  a_strobe_pulse: assert property (st.strobe[0] != '0 |=> st.strobe[0] == '0)
    else $error("phase strobe did not clear itself");
  a_trim_reset: assert property ($rose(rst_n) |-> O_REGULATOR_TRIM == TRIM_RESET)
    else $error("regulator trim not at reset value");
  a_status_readonly: assert property (
    wr_commit && idx >= IDX_EE_STATUS && idx <= IDX_STATUS_LAST |=> $stable(st.shadow))
    else $error("status copy changed by a write");
  a_crc_sets: assert property (I_EE_CRC_FAULT |=> st.live.crc_fault)
    else $error("crc fault not recorded");
  a_fault_sets: assert property (I_EE_FAULT |=> st.live.fault)
    else $error("transfer fault not recorded");
  a_download_live: assert property (
    I_EE_DOWNLOAD_BUSY [*2] |=> st.live.download)
    else $error("download busy not shown");
  a_upload_live: assert property (
    I_EE_UPLOAD_BUSY |=> st.live.upload ##1 (st.live.upload == $past(I_EE_UPLOAD_BUSY)))
    else $error("upload busy not shown");
  a_ready_single: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY ##1 !O_PREADY)
    else $error("pready not a single cycle answer");
  a_irq_level: assert property (O_IRQ == |(st.irq_status & st.irq_enable))
    else $error("interrupt output disagrees with status");

  c_phase_step: cover property (wr_commit && idx == IDX_LOOP0_PHASE && wbyte[PH_INC_BIT]);
  c_status_refresh: cover property (wr_commit && idx == IDX_XFER_STROBE && st.live.download);
  c_bus_error: cover property (O_PREADY && O_PSLVERR);
  c_irq_raised: cover property ($rose(O_IRQ));

endmodule
`default_nettype wire

// ---- common/pll_trim_pkg.sv ----
`default_nettype none
package pll_trim_pkg;

  // Bus and datapath widths
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 32;
  localparam int IDX_W     = 12;
  localparam int NUM_LOOPS = 4;
  localparam int STEP_W    = 16;
  localparam int PHASE_W   = 24;
  localparam int TRIM_W    = 10;
  localparam int IRQ_W     = 4;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_XFER_STROBE  = 12'h00f;
  localparam logic [IDX_W-1:0] IDX_STEP_LOW     = 12'h412;
  localparam logic [IDX_W-1:0] IDX_STEP_HIGH    = 12'h413;
  localparam logic [IDX_W-1:0] IDX_LOOP0_PHASE  = 12'ha24;
  localparam logic [IDX_W-1:0] IDX_LOOP_STRIDE  = 12'h020;
  localparam logic [IDX_W-1:0] IDX_TRIM_LOW     = 12'hb00;
  localparam logic [IDX_W-1:0] IDX_TRIM_HIGH    = 12'hb01;
  localparam logic [IDX_W-1:0] IDX_EE_STATUS    = 12'hd00;
  localparam logic [IDX_W-1:0] IDX_STATUS_LAST  = 12'hd05;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 12'he00;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE   = 12'he01;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR    = 12'he02;
  localparam logic [IDX_W-1:0] IDX_PHASE_READ0  = 12'he10;

  // Field positions of the phase strobe register
  localparam int PH_INC_BIT   = 0;
  localparam int PH_DEC_BIT   = 1;
  localparam int PH_RESET_BIT = 2;

  // Field positions of the transfer status register and interrupt bits
  localparam int ST_UPLOAD_BIT   = 0;
  localparam int ST_DOWNLOAD_BIT = 1;
  localparam int ST_FAULT_BIT    = 2;
  localparam int ST_CRC_BIT      = 3;
  localparam int IRQ_CRC_BIT     = 0;
  localparam int IRQ_FAULT_BIT   = 1;
  localparam int IRQ_DL_DONE_BIT = 2;
  localparam int IRQ_UL_DONE_BIT = 3;

  // Values and reset values
  localparam logic [7:0]        XFER_VALUE  = 8'h01;
  localparam logic [TRIM_W-1:0] TRIM_RESET  = 10'h000;
  localparam logic [STEP_W-1:0] STEP_RESET  = 16'h0000;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 24'h000000;
  localparam logic [IRQ_W-1:0]  IRQ_RESET   = 4'h0;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_phase_t;

  typedef struct packed {
    logic reset;
    logic dec;
    logic inc;
  } phase_strobe_t;

  typedef struct packed {
    logic crc_fault;
    logic fault;
    logic download;
    logic upload;
  } ee_status_t;

  typedef struct packed {
    logic [PHASE_W-1:0] offset;
  } accum_state_t;

endpackage
`default_nettype wire

// ---- rtl/phase_offset_accum.sv ----
`timescale 1ns/1ps
`default_nettype none
module phase_offset_accum
  import pll_trim_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire phase_strobe_t      i_strobe,
  input  wire logic [STEP_W-1:0]  i_step,
  output logic      [PHASE_W-1:0] o_offset
);

  accum_state_t st;
  accum_state_t next_st;

  // Reset beats both steps; opposite steps together cancel out
  always_comb begin
    next_st = st;
    if (i_strobe.reset) begin
      next_st.offset = PHASE_RESET;
    end else if (i_strobe.inc && !i_strobe.dec) begin
      next_st.offset = st.offset + PHASE_W'(i_step);
    end else if (i_strobe.dec && !i_strobe.inc) begin
      next_st.offset = st.offset - PHASE_W'(i_step);
    end
  end

  // Offset wraps modulo two to the width, as a phase should
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{offset: PHASE_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign o_offset = st.offset;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_reset_zeroes: assert property (i_strobe.reset |=> o_offset == PHASE_RESET)
    else $error("phase offset not zeroed by reset strobe");
  a_step_up: assert property (
    i_strobe.inc && !i_strobe.dec && !i_strobe.reset
    |=> o_offset == PHASE_W'($past(o_offset) + PHASE_W'($past(i_step))))
    else $error("increment did not add the step");
  a_step_down: assert property (
    i_strobe.dec && !i_strobe.inc && !i_strobe.reset
    |=> o_offset == PHASE_W'($past(o_offset) - PHASE_W'($past(i_step))))
    else $error("decrement did not subtract the step");
  a_idle_hold: assert property (i_strobe == '0 |=> $stable(o_offset))
    else $error("offset moved without a strobe");

endmodule
`default_nettype wire

// ---- verification/pll_trim_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_trim_regs_tb_top
  import pll_trim_pkg::*;
;
  logic                              clk;
  logic                              rst_b;
  logic                              psel;
  logic                              penable;
  logic                              pwrite;
  logic [ADDR_W-1:0]                 paddr;
  logic [DATA_W-1:0]                 pwdata;
  logic [3:0]                        pstrb;
  logic                              crc_fault;
  logic                              fault;
  logic                              dl_busy;
  logic                              ul_busy;
  logic [DATA_W-1:0]                 prdata;
  logic                              pready;
  logic                              pslverr;
  logic [NUM_LOOPS-1:0][PHASE_W-1:0] phase_offset;
  logic [TRIM_W-1:0]                 trim;
  logic                              irq;
  int                                n_fail;
  int                                checked;

  pll_trim_regs pll_trim_regs_i (
    .I_CLK_SYS          (clk),
    .I_RST_B            (rst_b),
    .I_PSEL             (psel),
    .I_PENABLE          (penable),
    .I_PWRITE           (pwrite),
    .I_PADDR            (paddr),
    .I_PWDATA           (pwdata),
    .I_PSTRB            (pstrb),
    .I_EE_CRC_FAULT     (crc_fault),
    .I_EE_FAULT         (fault),
    .I_EE_DOWNLOAD_BUSY (dl_busy),
    .I_EE_UPLOAD_BUSY   (ul_busy),
    .O_PRDATA           (prdata),
    .O_PREADY           (pready),
    .O_PSLVERR          (pslverr),
    .O_PHASE_OFFSET     (phase_offset),
    .O_REGULATOR_TRIM   (trim),
    .O_IRQ              (irq)
  );

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Verdict and end of run, shared by the main sequence and every timeout
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Four-state compare so an unknown never passes
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    pstrb   <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_fail++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write that must complete without an error response
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
    chk({31'h0, e}, 32'h00000000);
  endtask

  // Read compared against an expected word
  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h00000000);
  endtask

  // One-cycle pulse on one of the memory transfer fault inputs
  task automatic pulse(input logic crc);
    @(posedge clk);
    crc_fault <= crc;
    fault     <= ~crc;
    @(posedge clk);
    crc_fault <= 1'b0;
    fault     <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    logic [IDX_W-1:0] base;
    logic [IDX_W-1:0] ro;
    logic [31:0]      r;
    logic             e;
    n_fail = 0;
    checked = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    crc_fault = 1'b0;
    fault = 1'b0;
    dl_busy = 1'b0;
    ul_busy = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    // Trim resets to zero
    rdc(IDX_TRIM_LOW, 32'h00000000);
    rdc(IDX_TRIM_HIGH, 32'h00000000);
    chk({22'h0, trim}, 32'h00000000);
    // Step 0x1234, then every loop steps, wraps, ignores zeros and resets
    wr(IDX_STEP_LOW, 8'h34);
    wr(IDX_STEP_HIGH, 8'h12);
    for (int k = 0; k < NUM_LOOPS; k++) begin
      base = IDX_LOOP0_PHASE + IDX_LOOP_STRIDE * k[IDX_W-1:0];
      ro = IDX_PHASE_READ0 + k[IDX_W-1:0];
      wr(base, 8'h01);
      rdc(ro, 32'h00001234);
      chk({8'h0, phase_offset[(k + 1) % NUM_LOOPS]}, 32'h00000000);
      wr(base, 8'h01);
      rdc(ro, 32'h00002468);
      repeat (3) wr(base, 8'h02);
      rdc(ro, 32'h00ffedcc);
      chk({8'h0, phase_offset[k]}, 32'h00ffedcc);
      wr(base, 8'h00);
      rdc(ro, 32'h00ffedcc);
      wr(base, 8'h03);
      rdc(ro, 32'h00ffedcc);
      rdc(base, 32'h00000000);
      wr(base, 8'h07);
      rdc(ro, 32'h00000000);
    end
    // Trim all ones, then back to all zeros
    wr(IDX_TRIM_LOW, 8'hff);
    wr(IDX_TRIM_HIGH, 8'h03);
    #1 chk({22'h0, trim}, 32'h000003ff);
    rdc(IDX_TRIM_HIGH, 32'h00000003);
    wr(IDX_TRIM_LOW, 8'h00);
    wr(IDX_TRIM_HIGH, 8'h00);
    #1 chk({22'h0, trim}, 32'h00000000);
    // Download busy shows only after the transfer strobe
    @(posedge clk);
    dl_busy <= 1'b1;
    repeat (2) @(posedge clk);
    wr(IDX_XFER_STROBE, XFER_VALUE);
    rdc(IDX_EE_STATUS, 32'h00000002);
    dl_busy <= 1'b0;
    pulse(1'b1);
    pulse(1'b0);
    rdc(IDX_EE_STATUS, 32'h00000002);
    wr(IDX_XFER_STROBE, XFER_VALUE);
    rdc(IDX_EE_STATUS, 32'h0000000c);
    // Writes into the status range change nothing
    wr(IDX_EE_STATUS, 8'h00);
    rdc(IDX_EE_STATUS, 32'h0000000c);
    wr(IDX_STATUS_LAST, 8'hff);
    rdc(IDX_STATUS_LAST, 32'h00000000);
    // Upload start clears the sticky faults
    ul_busy <= 1'b1;
    repeat (2) @(posedge clk);
    // Any other value on the transfer strobe leaves the copy alone
    wr(IDX_XFER_STROBE, 8'h02);
    rdc(IDX_EE_STATUS, 32'h0000000c);
    wr(IDX_XFER_STROBE, XFER_VALUE);
    rdc(IDX_EE_STATUS, 32'h00000001);
    ul_busy <= 1'b0;
    repeat (2) @(posedge clk);
    // Interrupt: sticky, masked, enabled, cleared
    rdc(IDX_IRQ_STATUS, 32'h0000000f);
    wr(IDX_IRQ_CLEAR, 8'h0f);
    rdc(IDX_IRQ_STATUS, 32'h00000000);
    wr(IDX_IRQ_ENABLE, 8'h00);
    pulse(1'b1);
    rdc(IDX_IRQ_STATUS, 32'h00000001);
    #1 chk({31'h0, irq}, 32'h00000000);
    wr(IDX_IRQ_ENABLE, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h00000001);
    wr(IDX_IRQ_CLEAR, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h00000000);
    rdc(IDX_IRQ_ENABLE, 32'h00000001);
    // Unmapped address answers with an error and reads zero
    apb(1'b0, 12'h001, 8'h00, r, e);
    chk({31'h0, e}, 32'h00000001);
    chk(r, 32'h00000000);
    wrap_up();
  end
endmodule
`default_nettype wire
